// ### hdl/awt_wave_timer.sv
// Chosen here: the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module awt_wave_timer
   import awt_pkg::*;
(
   input  wire logic              i_clk,
   input  wire logic              i_nrst,
   input  wire logic              i_comp_uf,
   input  wire logic [ADDR_W-1:0] i_s_axi_awaddr,
   input  wire logic              i_s_axi_awvalid,
   output logic                   o_s_axi_awready,
   input  wire logic [31:0]       i_s_axi_wdata,
   input  wire logic [3:0]        i_s_axi_wstrb,
   input  wire logic              i_s_axi_wvalid,
   output logic                   o_s_axi_wready,
   output logic [1:0]             o_s_axi_bresp,
   output logic                   o_s_axi_bvalid,
   input  wire logic              i_s_axi_bready,
   input  wire logic [ADDR_W-1:0] i_s_axi_araddr,
   input  wire logic              i_s_axi_arvalid,
   output logic                   o_s_axi_arready,
   output logic [31:0]            o_s_axi_rdata,
   output logic [1:0]             o_s_axi_rresp,
   output logic                   o_s_axi_rvalid,
   input  wire logic              i_s_axi_rready,
   output logic                   o_wave_out_pin,
   output logic                   o_wave_oe,
   output logic                   o_timer_irq
);
   logic [ADDR_W-1:0] aw_addr, next_aw_addr;
   logic              aw_held, next_aw_held;
   logic [7:0]        w_byte, next_w_byte;
   logic              w_lane, next_w_lane;
   logic              w_held, next_w_held;
   logic              next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
   logic [1:0]        next_bresp, next_rresp;
   logic [31:0]       next_rdata;
   logic [7:0]        mode, next_mode;
   logic [7:0]        outctl, next_outctl;
   logic [7:0]        swctl, next_swctl;
   awt_src_t          src, next_src;
   logic [7:0]        pre_rel, next_pre_rel;
   logic [7:0]        sec_stage, next_sec_stage;
   logic [7:0]        pend_prim, next_pend_prim;
   logic [7:0]        pend_sec, next_pend_sec;
   logic              pend, next_pend;
   logic [7:0]        prim_act, next_prim_act;
   logic [7:0]        sec_act, next_sec_act;
   logic [7:0]        pre_cnt, next_pre_cnt;
   logic [7:0]        cnt, next_cnt;
   logic              phase, next_phase;
   logic              sw_act, next_sw_act;
   logic              run_q, next_run_q;
   logic [2:0]        div, next_div;
   logic              next_wave, next_oe, next_irq;
   logic              pwg, run, start, tick, wr_en, rd_en, hit_w, hit_r;
   function automatic logic mapped(input logic [ADDR_W-1:0] a);
      mapped = (a == OFS_MODE) || (a == OFS_OUTCTL) || (a == OFS_PRESC) || (a == OFS_SEC)
            || (a == OFS_PRIM) || (a == OFS_SWCTL) || (a == OFS_SRC);
   endfunction : mapped
   always_comb
   begin
      pwg   = (mode[BIT_MODE_HI:BIT_MODE_LO] == MODE_PWG);
      run   = pwg && mode[BIT_RUN];
      start = run && !run_q;
      unique case (src)
         SRC_F1:   tick = 1'b1;
         SRC_F2:   tick = div[0];
         SRC_F8:   tick = (div == DIV8_LAST);
         SRC_COMP: tick = i_comp_uf;
      endcase
      // write is applied once both address and data sit in their holding slots
      wr_en = aw_held && w_held && !o_s_axi_bvalid;
      hit_w = mapped(aw_addr);
      rd_en = i_s_axi_arvalid && o_s_axi_arready;
      hit_r = mapped(i_s_axi_araddr);
      next_aw_addr   = aw_addr;
      next_aw_held   = aw_held;
      next_w_byte    = w_byte;
      next_w_lane    = w_lane;
      next_w_held    = w_held;
      next_bvalid    = o_s_axi_bvalid;
      next_bresp     = o_s_axi_bresp;
      next_rvalid    = o_s_axi_rvalid;
      next_rresp     = o_s_axi_rresp;
      next_rdata     = o_s_axi_rdata;
      next_mode      = mode;
      next_outctl    = outctl;
      next_swctl     = swctl;
      next_src       = src;
      next_pre_rel   = pre_rel;
      next_sec_stage = sec_stage;
      next_pend_prim = pend_prim;
      next_pend_sec  = pend_sec;
      next_pend      = pend;
      next_prim_act  = prim_act;
      next_sec_act   = sec_act;
      next_pre_cnt   = pre_cnt;
      next_cnt       = cnt;
      next_phase     = phase;
      next_sw_act    = sw_act;
      next_run_q     = run;
      next_div       = div + 3'h1;
      next_irq       = 1'b0;
      if (i_s_axi_awvalid && o_s_axi_awready)
      begin
         next_aw_addr = i_s_axi_awaddr;
         next_aw_held = 1'b1;
      end
      if (i_s_axi_wvalid && o_s_axi_wready)
      begin
         next_w_byte = i_s_axi_wdata[7:0];
         next_w_lane = i_s_axi_wstrb[0];
         next_w_held = 1'b1;
      end
      if (o_s_axi_bvalid && i_s_axi_bready)
         next_bvalid = 1'b0;
      if (wr_en)
      begin
         next_aw_held = 1'b0;
         next_w_held  = 1'b0;
         next_bvalid  = 1'b1;
         next_bresp   = hit_w ? RESP_OKAY : RESP_DECERR;
      end
      if (o_s_axi_rvalid && i_s_axi_rready)
         next_rvalid = 1'b0;
      if (rd_en)
      begin
         next_rvalid = 1'b1;
         next_rresp  = hit_r ? RESP_OKAY : RESP_DECERR;
         unique case (i_s_axi_araddr)
            OFS_MODE:   next_rdata = {24'h0, mode};
            OFS_OUTCTL: next_rdata = {24'h0, outctl};
            OFS_PRESC:  next_rdata = {24'h0, pre_cnt};
            OFS_SEC:    next_rdata = {24'h0, sec_stage};
            OFS_PRIM:   next_rdata = {24'h0, cnt};
            OFS_SWCTL:  next_rdata = {24'h0, swctl};
            OFS_SRC:    next_rdata = {30'h0, src};
            default:    next_rdata = 32'h0;
         endcase
      end
      // timer core
      if (start)
      begin
         next_pre_cnt = pre_rel;
         next_phase   = 1'b0;
         next_sw_act  = swctl[BIT_SWSEL];
         if (pend)
         begin
            next_prim_act = pend_prim;
            next_sec_act  = pend_sec;
            next_cnt      = pend_prim;
            next_pend     = 1'b0;
         end
         else
            next_cnt = prim_act;
      end
      else if (run && tick)
      begin
         if (pre_cnt != 8'h0)
            next_pre_cnt = pre_cnt - 8'h1;
         else
         begin
            next_pre_cnt = pre_rel;
            if (cnt != 8'h0)
               next_cnt = cnt - 8'h1;
            else if (!phase)
            begin
               next_phase = 1'b1;
               next_cnt   = sec_act;
            end
            else
            begin
               next_phase  = 1'b0;
               next_irq    = 1'b1;
               next_sw_act = swctl[BIT_SWSEL];
               if (pend)
               begin
                  next_prim_act = pend_prim;
                  next_sec_act  = pend_sec;
                  next_cnt      = pend_prim;
                  next_pend     = 1'b0;
               end
               else
                  next_cnt = prim_act;
            end
         end
      end
      // register writes after the core so a fresh primary write re-arms pend
      if (wr_en && w_lane)
      begin
         unique case (aw_addr)
            OFS_MODE:   next_mode    = w_byte & MASK_MODE;
            OFS_OUTCTL: next_outctl  = w_byte & MASK_OUTCTL;
            OFS_PRESC:  next_pre_rel = w_byte;
            OFS_SEC:    next_sec_stage = w_byte;
            OFS_PRIM:
            begin
               next_pend_prim = w_byte;
               next_pend_sec  = sec_stage;
               next_pend      = 1'b1;
            end
            OFS_SWCTL:  next_swctl = w_byte & MASK_SWCTL;
            OFS_SRC:    next_src   = awt_src_t'(w_byte[1:0]);
            default:    next_src   = src;
         endcase
      end
      // pin follows the next phase so it moves on the same edge as the request
      next_oe = pwg;
      if (!pwg)
         next_wave = 1'b0;
      else if (!run)
         next_wave = o_wave_out_pin;
      else if (next_sw_act)
         next_wave = swctl[BIT_FIXLVL];
      else
         next_wave = next_phase ^ !outctl[BIT_LVL];
      next_awready = !next_aw_held && !next_bvalid;
      next_wready  = !next_w_held && !next_bvalid;
      next_arready = !next_rvalid;
   end
   always_ff @(posedge i_clk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         aw_addr <= '0;
         aw_held <= 1'b0;
         w_byte <= 8'h00;
         w_lane <= 1'b0;
         w_held <= 1'b0;
         o_s_axi_awready <= 1'b0;
         o_s_axi_wready <= 1'b0;
         o_s_axi_bvalid <= 1'b0;
         o_s_axi_bresp <= RESP_OKAY;
         o_s_axi_arready <= 1'b0;
         o_s_axi_rvalid <= 1'b0;
         o_s_axi_rresp <= RESP_OKAY;
         o_s_axi_rdata <= 32'h0;
         mode <= RST_MODE;
         outctl <= RST_OUTCTL;
         swctl <= RST_SWCTL;
         src <= SRC_F1;
         pre_rel <= RST_COUNT;
         sec_stage <= RST_COUNT;
         pend_prim <= RST_COUNT;
         pend_sec <= RST_COUNT;
         pend <= 1'b0;
         prim_act <= RST_COUNT;
         sec_act <= RST_COUNT;
         pre_cnt <= RST_COUNT;
         cnt <= RST_COUNT;
         phase <= 1'b0;
         sw_act <= 1'b0;
         run_q <= 1'b0;
         div <= 3'h0;
         o_wave_out_pin <= 1'b0;
         o_wave_oe <= 1'b0;
         o_timer_irq <= 1'b0;
      end
      else
      begin
         aw_addr <= next_aw_addr;
         aw_held <= next_aw_held;
         w_byte <= next_w_byte;
         w_lane <= next_w_lane;
         w_held <= next_w_held;
         o_s_axi_awready <= next_awready;
         o_s_axi_wready <= next_wready;
         o_s_axi_bvalid <= next_bvalid;
         o_s_axi_bresp <= next_bresp;
         o_s_axi_arready <= next_arready;
         o_s_axi_rvalid <= next_rvalid;
         o_s_axi_rresp <= next_rresp;
         o_s_axi_rdata <= next_rdata;
         mode <= next_mode;
         outctl <= next_outctl;
         swctl <= next_swctl;
         src <= next_src;
         pre_rel <= next_pre_rel;
         sec_stage <= next_sec_stage;
         pend_prim <= next_pend_prim;
         pend_sec <= next_pend_sec;
         pend <= next_pend;
         prim_act <= next_prim_act;
         sec_act <= next_sec_act;
         pre_cnt <= next_pre_cnt;
         cnt <= next_cnt;
         phase <= next_phase;
         sw_act <= next_sw_act;
         run_q <= next_run_q;
         div <= next_div;
         o_wave_out_pin <= next_wave;
         o_wave_oe <= next_oe;
         o_timer_irq <= next_irq;
      end
   end
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_nrst);
   a_irq_sec_end: assert property (
      o_timer_irq |-> ($past(phase) && !phase))
      else $error("irq not at end of secondary phase");
   a_uf_alternate: assert property (
      (run && !start && tick && pre_cnt == 8'h0 && cnt == 8'h0)
      |=> (phase != $past(phase)))
      else $error("underflow did not switch phase");
   a_start_primary: assert property (
      start |=> (!phase && pre_cnt == $past(pre_rel)))
      else $error("start did not open primary phase");
   a_pre_reload: assert property (
      (run && !start && tick && pre_cnt == 8'h0) |=> (pre_cnt == $past(pre_rel)))
      else $error("prescaler did not reload");
   a_cnt_hold: assert property (
      (run && !start && tick && pre_cnt != 8'h0) |=> (cnt == $past(cnt)))
      else $error("counter moved mid prescale");
   a_stop_freeze: assert property (
      (!run && !$past(run)) |=> (cnt == $past(cnt) && pre_cnt == $past(pre_cnt)))
      else $error("counter moved while stopped");
   a_reload_only: assert property (
      (wr_en && aw_addr == OFS_PRIM && !start && !(run && tick && pre_cnt == 8'h00))
      |=> (cnt == $past(cnt)))
      else $error("primary write reached counter");
   a_level_sel: assert property (
      (run && $past(run) && !sw_act && $stable(outctl))
      |-> (o_wave_out_pin == (phase ^ !outctl[BIT_LVL])))
      else $error("pin level wrong for phase");
   a_pin_owned: assert property (
      (pwg && $past(pwg)) |-> o_wave_oe)
      else $error("pin not driven in waveform mode");
   a_bresp_hold: assert property (
      (o_s_axi_bvalid && !i_s_axi_bready) |=> $stable(o_s_axi_bvalid))
      else $error("write response dropped");
   c_irq: cover property (o_timer_irq ##1 1'b1 [*3] ##1 o_timer_irq);
   c_pend_apply: cover property (pend ##1 !pend && run);
   c_fixed: cover property (run && sw_act);
   c_decerr: cover property (o_s_axi_rvalid && o_s_axi_rresp == RESP_DECERR);
endmodule : awt_wave_timer
`default_nettype wire

// ### hdl/awt_pkg.sv
package awt_pkg;
   localparam int        ADDR_W      = 8;
   localparam bit [7:0]  OFS_MODE    = 8'h80;
   localparam bit [7:0]  OFS_OUTCTL  = 8'h84;
   localparam bit [7:0]  OFS_PRESC   = 8'h88;
   localparam bit [7:0]  OFS_SEC     = 8'h8C;
   localparam bit [7:0]  OFS_PRIM    = 8'h90;
   localparam bit [7:0]  OFS_SWCTL   = 8'h94;
   localparam bit [7:0]  OFS_SRC     = 8'h98;
   localparam int        BIT_RUN     = 7;
   localparam int        BIT_WTS     = 6;
   localparam int        BIT_MODE_HI = 5;
   localparam int        BIT_MODE_LO = 4;
   localparam bit [1:0]  MODE_PWG    = 2'h1;
   localparam int        BIT_LVL     = 5;
   localparam int        BIT_SWSEL   = 2;
   localparam int        BIT_FIXLVL  = 0;
   localparam bit [7:0]  MASK_MODE   = 8'hF0;
   localparam bit [7:0]  MASK_OUTCTL = 8'hE0;
   localparam bit [7:0]  MASK_SWCTL  = 8'h05;
   localparam bit [7:0]  RST_MODE    = 8'h00;
   localparam bit [7:0]  RST_OUTCTL  = 8'h00;
   localparam bit [7:0]  RST_SWCTL   = 8'h00;
   localparam bit [7:0]  RST_COUNT   = 8'hFF;
   localparam bit [2:0]  DIV8_LAST   = 3'h7;
   localparam bit [1:0]  RESP_OKAY   = 2'h0;
   localparam bit [1:0]  RESP_DECERR = 2'h3;
   typedef enum logic [1:0] {SRC_F1, SRC_F2, SRC_F8, SRC_COMP} awt_src_t;
endpackage : awt_pkg

// ### test/awt_pin_load.sv
`timescale 1ns/1ps
`default_nettype none
module awt_pin_load
(
   input  wire logic        i_clk,
   input  wire logic        i_nrst,
   input  wire logic        i_pin,
   input  wire logic        i_irq,
   output logic      [15:0] o_hi,
   output logic      [15:0] o_lo,
   output logic      [15:0] o_gap
);
   logic [15:0] run;
   logic [15:0] irun;
   logic        prev;
   // passive load: times each pin level and the irq spacing, the pin has no pull to fall back on
   always_ff @(posedge i_clk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         run   <= 16'h0000;
         irun  <= 16'h0000;
         prev  <= 1'b0;
         o_hi  <= 16'h0000;
         o_lo  <= 16'h0000;
         o_gap <= 16'h0000;
      end
      else
      begin
         prev <= i_pin;
         run  <= (i_pin !== prev) ? 16'h0001 : run + 16'h0001;
         irun <= i_irq ? 16'h0001 : irun + 16'h0001;
         if ((i_pin !== prev) && prev)
            o_hi <= run;
         if ((i_pin !== prev) && !prev)
            o_lo <= run;
         if (i_irq)
            o_gap <= irun;
      end
   end
endmodule : awt_pin_load
`default_nettype wire

// ### test/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top
   import awt_pkg::*;
();
   logic              clk, nrst, comp, awv, awr, wv, wrdy, bv, br, arv, arr, rv, rr;
   logic              pin, oe, irq;
   logic [ADDR_W-1:0] awa, ara;
   logic [31:0]       wda, rda, d, d2;
   logic [3:0]        ws;
   logic [1:0]        bresp, rresp, rsp, cc;
   logic [15:0]       hi, lo, gap;
   int                num_errors, n_checks, i, pl, sl;
   int                pr[4] = '{0, 1, 0, 2};
   int                pm[4] = '{1, 2, 0, 1};
   int                sc[4] = '{0, 1, 2, 0};
   int                lv[4] = '{0, 1, 0, 1};
   int                dv[4] = '{1, 2, 8, 3};

   awt_wave_timer u_dut (.i_clk(clk), .i_nrst(nrst), .i_comp_uf(comp),
      .i_s_axi_awaddr(awa), .i_s_axi_awvalid(awv), .o_s_axi_awready(awr),
      .i_s_axi_wdata(wda), .i_s_axi_wstrb(ws), .i_s_axi_wvalid(wv), .o_s_axi_wready(wrdy),
      .o_s_axi_bresp(bresp), .o_s_axi_bvalid(bv), .i_s_axi_bready(br),
      .i_s_axi_araddr(ara), .i_s_axi_arvalid(arv), .o_s_axi_arready(arr),
      .o_s_axi_rdata(rda), .o_s_axi_rresp(rresp), .o_s_axi_rvalid(rv), .i_s_axi_rready(rr),
      .o_wave_out_pin(pin), .o_wave_oe(oe), .o_timer_irq(irq));
   awt_pin_load u_load (.i_clk(clk), .i_nrst(nrst), .i_pin(pin), .i_irq(irq),
      .o_hi(hi), .o_lo(lo), .o_gap(gap));

   always #10 clk = ~clk;

   // companion underflow, one pulse every third clock
   always @(posedge clk)
   begin
      if (!nrst)
      begin
         cc   <= 2'h0;
         comp <= 1'b0;
      end
      else
      begin
         cc   <= (cc == 2'h2) ? 2'h0 : cc + 2'h1;
         comp <= (cc == 2'h2);
      end
   end

   task automatic wrap_up;
      $display("checks %0d mismatches %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : wrap_up

   task automatic chk(input logic ok, input string m);
      n_checks++;
      if (ok !== 1'b1)
      begin
         num_errors++;
         $display("[ERR] %0t %s", $time, m);
      end
   endtask : chk

   task automatic tmo;
      num_errors++;
      $display("[ERR] %0t wait limit ran out", $time);
      wrap_up();
   endtask : tmo

   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      int n;
      @(posedge clk);
      awa <= a;
      awv <= 1'b1;
      wda <= {24'h0, v};
      wv  <= 1'b1;
      for (n = 0; n < 50; n++)
      begin
         @(posedge clk);
         if (awr)
            awv <= 1'b0;
         if (wrdy)
            wv <= 1'b0;
         // bready comes a cycle late so the slave must hold its response
         if (bv && br)
            break;
         if (bv)
            br <= 1'b1;
      end
      rsp = bresp;
      br <= 1'b0;
      if (n == 50)
         tmo();
   endtask : wr

   task automatic rd(input logic [7:0] a);
      int n;
      @(posedge clk);
      ara <= a;
      arv <= 1'b1;
      rr  <= 1'b1;
      for (n = 0; n < 50; n++)
      begin
         @(posedge clk);
         if (arr)
            arv <= 1'b0;
         if (rv)
            break;
      end
      d = rda;
      rsp = rresp;
      rr <= 1'b0;
      if (n == 50)
         tmo();
   endtask : rd

   task automatic rck(input logic [7:0] a, input logic [7:0] e);
      rd(a);
      chk(d === {24'h0, e} && rsp === RESP_OKAY, "register read value");
   endtask : rck

   task automatic wirq(input int k);
      int n;
      int c;
      c = 0;
      for (n = 0; n < 3000 && c < k; n++)
      begin
         @(posedge clk);
         if (irq === 1'b1)
            c++;
      end
      if (c < k)
         tmo();
   endtask : wirq

   task automatic hold(input logic v, input int k);
      logic ok;
      ok = 1'b1;
      repeat (k)
      begin
         @(posedge clk);
         if (pin !== v)
            ok = 1'b0;
      end
      chk(ok, "pin level moved");
   endtask : hold

   task automatic cfg(input logic [7:0] p, m, s, src, oc);
      wr(OFS_MODE, 8'h50);
      wr(OFS_PRESC, p);
      wr(OFS_SEC, s);
      wr(OFS_PRIM, m);
      wr(OFS_SRC, src);
      wr(OFS_OUTCTL, oc);
      wr(OFS_SWCTL, 8'h00);
      wr(OFS_MODE, 8'hD0);
   endtask : cfg

   initial
   begin
      clk = 1'b0;
      nrst = 1'b0;
      {awv, wv, br, arv, rr} = 5'h00;
      {awa, ara, wda} = '0;
      ws = 4'hF;
      num_errors = 0;
      n_checks = 0;
      repeat (20) @(posedge clk);
      nrst <= 1'b1;
      @(posedge clk);
      rck(OFS_MODE, RST_MODE);
      rck(OFS_OUTCTL, RST_OUTCTL);
      rck(OFS_SWCTL, RST_SWCTL);
      rck(OFS_PRIM, RST_COUNT);
      rd(8'hFC);
      chk(rsp === RESP_DECERR && d === 32'h0, "unmapped read");
      wr(8'hFC, 8'h5A);
      chk(rsp === RESP_DECERR, "unmapped write");
      ws <= 4'hE;
      wr(OFS_OUTCTL, 8'h20);
      chk(rsp === RESP_OKAY, "masked write response");
      ws <= 4'hF;
      rck(OFS_OUTCTL, RST_OUTCTL);
      wr(OFS_MODE, 8'h80);
      repeat (3) @(posedge clk);
      chk(oe === 1'b0, "pin driven outside waveform mode");
      $display("test reset and map done");
      for (i = 0; i < 4; i++)
      begin
         cfg(8'(pr[i]), 8'(pm[i]), 8'(sc[i]), 8'(i), 8'(lv[i] * 32));
         chk(oe === 1'b1, "pin not driven in waveform mode");
         pl = (pr[i] + 1) * (pm[i] + 1) * dv[i];
         sl = (pr[i] + 1) * (sc[i] + 1) * dv[i];
         wirq(3);
         chk(pin === (lv[i] == 0), "level at phase start");
         @(posedge clk);
         chk(hi === 16'(lv[i] ? sl : pl), "high width");
         chk(lo === 16'(lv[i] ? pl : sl), "low width");
         chk(gap === 16'(pl + sl), "request spacing");
         $display("test source %0d done", i);
      end
      wr(OFS_MODE, 8'h50);
      hold(pin, 40);
      $display("test stop done");
      cfg(8'h00, 8'h40, 8'h40, 8'h00, 8'h00);
      rck(OFS_PRESC, 8'h00);
      rck(OFS_SEC, 8'h40);
      for (i = 0; i < 2; i++)
      begin
         if (i == 1)
            repeat (70) @(posedge clk);
         rd(OFS_PRIM);
         d2 = d;
         rd(OFS_PRIM);
         chk((d < d2) === 1'b1 && (d2 <= 32'h40) === 1'b1, "live count");
      end
      chk(pin === 1'b0, "secondary phase level");
      $display("test count read done");
      cfg(8'h00, 8'h01, 8'h00, 8'h00, 8'h00);
      wr(OFS_SEC, 8'h03);
      wirq(2);
      @(posedge clk);
      chk(lo === 16'h0001, "secondary used before primary write");
      wr(OFS_PRIM, 8'h02);
      wirq(3);
      @(posedge clk);
      chk(hi === 16'h0003 && lo === 16'h0004, "new widths");
      wr(OFS_SWCTL, 8'h05);
      wirq(1);
      hold(1'b1, 40);
      wr(OFS_SWCTL, 8'h00);
      wirq(3);
      @(posedge clk);
      chk(hi === 16'h0003 && lo === 16'h0004, "toggling back");
      $display("test reload and switch done");
      wrap_up();
   end
endmodule : tb_top
`default_nettype wire
